// ---- hbp_pkg.sv ----
/*
 package of the dual-mode host bus port: location map, bit positions,
 reset values, bus styles, controller register map and timing counts.
 assumes one 50 MHz clock shared by both ends.
*/
// Notes on behaviour
// - ALE held high: data-strobe style
// - ALE held low: separate strobes, address lines
// - any ALE edge selects multiplexed style
// - multiplexed style sticks until hardware reset
// - ALE high latches address from shared bus
// - respond only while chip select is low
// - direction pin 1 reads, 0 writes
// - data strobe rising edge ends a cycle
// - read strobe reads, write strobe writes
// - one open-drain interrupt line, pulls low
// - host decodes A0-3, holds A4-7 zero
// - without soft reset A0-2 suffice
// - host never touches 09h and above
// - multiplexed style: address pins tied high
// - location 08h bit 0 is soft reset
// - location 07h bit 2 masks interrupt
package hbp_pkg;
   // clock and strobe timing
   localparam int CLK_NS = 20;
   localparam int STRB_NS = 80;
   localparam int STRB_CYC = (STRB_NS + CLK_NS - 1) / CLK_NS;
   localparam logic [2:0] STRB_CNT = 3'(STRB_CYC - 1);
   // device location map
   localparam int NUM_DATA_LOC = 7;
   localparam logic [3:0] LOC_IRQ = 4'h7;
   localparam logic [3:0] LOC_SRST = 4'h8;
   localparam int MSK_BIT = 2;
   localparam int SRST_BIT = 0;
   localparam logic MSK_RST = 1'b1;
   localparam logic [7:0] MUX_APIN = 8'hFF;
   localparam logic [7:0] BUS_IDLE = 8'hFF;
   // bus styles
   typedef enum logic [1:0] {
      MODE_DS = 2'b00,
      MODE_SEP = 2'b01,
      MODE_MUX = 2'b11
   } hbp_mode_type;
   // controller states, gray from H_IDLE through H_END along the mux path
   typedef enum logic [2:0] {
      H_IDLE = 3'b000,
      H_ALE = 3'b001,
      H_SET = 3'b011,
      H_STRB = 3'b010,
      H_END = 3'b110
   } hbp_state_type;
   // controller register offsets
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_CMD = 8'h04;
   localparam logic [7:0] OFS_RDAT = 8'h08;
   localparam logic [7:0] OFS_ISTA = 8'h0C;
   localparam logic [7:0] OFS_IMSK = 8'h10;
   // controller field positions
   localparam int CMD_WDAT_LSB = 8;
   localparam int CMD_RD_BIT = 16;
   localparam int RDAT_BUSY_BIT = 8;
   localparam int IST_DONE = 0;
   localparam int IST_DINT = 1;
   localparam int IST_BAD = 2;
   localparam logic [2:0] IMSK_RST = 3'h0;
endpackage

// ---- hbp_if.sv ----
/*
 pin-level carrier between the host controller and the device port.
 resolves the shared data bus and the open-drain interrupt line.
*/
interface hbp_if;
   logic cs_n, rd_n, wr_n, cycle_strobe_pin, rw, ale;
   logic [7:0] a, hd_o, dd_o, ad;
   logic hd_oe, dd_oe, int_oe, int_n;
   // undriven bus floats high through pull-ups
   assign ad = dd_oe ? dd_o : (hd_oe ? hd_o : 8'hFF);
   // open drain: low while the device pulls
   assign int_n = ~int_oe;
   modport dev (
      input cs_n, rd_n, wr_n, cycle_strobe_pin, rw, ale, a, ad,
      output dd_o, dd_oe, int_oe
   );
   modport host (
      output cs_n, rd_n, wr_n, cycle_strobe_pin, rw, ale, a, hd_o, hd_oe,
      input ad, int_n
   );
endinterface

// ---- hbp_edge.sv ----
/*
 level sampler with edge detect, used on strobes and pins.
 assumes the input is synchronous to pclk.
*/
module hbp_edge (
   // clock, reset, enable
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,
   // sampled level
   input wire logic din,
   // previous level and edges
   output logic prev,
   output logic rise,
   output logic fall
);
   logic prev_q, primed_q;

   // previous sample; no edge before the first one
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prev_q <= 1'b1;
         primed_q <= 1'b0;
      end else if (ce) begin
         prev_q <= din;
         primed_q <= 1'b1;
      end
   end

   // edge decode
   assign prev = prev_q;
   assign rise = primed_q & ~prev_q & din;
   assign fall = primed_q & prev_q & ~din;
endmodule // hbp_edge

// ---- hbp_dev.sv ----
/*
 device end of the host bus port: bus style selection, address capture,
 read and write cycles on nine locations, interrupt pin, soft reset.
 assumes host pins synchronous to pclk and strobes several cycles wide.
*/
module hbp_dev
   import hbp_pkg::*;
(
   // clock, reset, enable
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,
   // host pins
   hbp_if.dev bus,
   // mailbox core side
   input wire logic core_irq,
   output logic core_rst,
   output logic wr_stb,
   output logic [3:0] wr_idx,
   output logic [7:0] wr_data,
   output logic rd_stb,
   output logic [3:0] rd_idx,
   output hbp_mode_type bus_mode
);
   hbp_mode_type mode_q;
   logic mode_ok_q;
   logic [7:0] mux_addr_q;
   logic [7:0] addr_prev_q;
   logic [7:0] bus_prev_q;
   logic cs_prev_q, rw_prev_q;
   logic [7:0] loc_q [NUM_DATA_LOC];
   logic msk_q, srst_q;
   logic [7:0] dd_q;
   logic oe_q, int_q;
   logic wr_stb_q, rd_stb_q;
   logic [3:0] wr_idx_q, rd_idx_q;
   logic [7:0] wr_data_q;
   logic ale_rise, ale_fall, ale_prev;
   logic ds_rise, rd_rise, wr_rise;
   logic [7:0] cur_addr;
   logic rd_now, wr_end, rd_end;

   // edge detectors on the control pins
   hbp_edge u_ale (
      .pclk(pclk),
      .presetn(presetn),
      .ce(ce),
      .din(bus.ale),
      .prev(ale_prev),
      .rise(ale_rise),
      .fall(ale_fall)
   );
   hbp_edge u_ds (
      .pclk(pclk),
      .presetn(presetn),
      .ce(ce),
      .din(bus.cycle_strobe_pin),
      .prev(),
      .rise(ds_rise),
      .fall()
   );
   hbp_edge u_rd (
      .pclk(pclk),
      .presetn(presetn),
      .ce(ce),
      .din(bus.rd_n),
      .prev(),
      .rise(rd_rise),
      .fall()
   );
   hbp_edge u_wr (
      .pclk(pclk),
      .presetn(presetn),
      .ce(ce),
      .din(bus.wr_n),
      .prev(),
      .rise(wr_rise),
      .fall()
   );

   // bus style: strap caught after release, any ale edge forces mux
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mode_q <= MODE_DS;
         mode_ok_q <= 1'b0;
      end else if (ce) begin
         mode_ok_q <= 1'b1;
         if (ale_rise || ale_fall) begin
            mode_q <= MODE_MUX;
         end else if (!mode_ok_q) begin
            mode_q <= bus.ale ? MODE_DS : MODE_SEP;
         end
         // no path leaves mux except the reset above
      end
   end

   // address latch while ale is high, mux style only
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mux_addr_q <= 8'h00;
      end else if (ce && mode_q == MODE_MUX && bus.ale) begin
         mux_addr_q <= bus.ad;
      end
   end

   // address source per style
   assign cur_addr = (mode_q == MODE_MUX) ? mux_addr_q : bus.a;

   // one-cycle history used when a strobe ends
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         addr_prev_q <= 8'h00;
         bus_prev_q <= 8'h00;
         cs_prev_q <= 1'b1;
         rw_prev_q <= 1'b1;
      end else if (ce) begin
         addr_prev_q <= cur_addr;
         bus_prev_q <= bus.ad;
         cs_prev_q <= bus.cs_n;
         rw_prev_q <= bus.rw;
      end
   end

   // cycle decode
   always_comb begin
      if (mode_q == MODE_DS) begin
         rd_now = ~bus.cs_n & ~bus.cycle_strobe_pin & bus.rw;
         wr_end = ds_rise & ~cs_prev_q & ~rw_prev_q;
         rd_end = ds_rise & ~cs_prev_q & rw_prev_q;
      end else begin
         rd_now = ~bus.cs_n & ~bus.rd_n;
         wr_end = wr_rise & ~cs_prev_q;
         rd_end = rd_rise & ~cs_prev_q;
      end
   end

   // soft reset bit survives its own effect
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         srst_q <= 1'b0;
      end else if (ce && wr_end && addr_prev_q == {4'h0, LOC_SRST}) begin
         srst_q <= bus_prev_q[SRST_BIT];
      end
   end

   // data locations, cleared while soft reset is set
   generate
      for (genvar i = 0; i < NUM_DATA_LOC; i++) begin : g_loc
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               loc_q[i] <= 8'h00;
            end else if (ce) begin
               if (srst_q) begin
                  loc_q[i] <= 8'h00;
               end else if (wr_end && addr_prev_q == 8'(i)) begin
                  loc_q[i] <= bus_prev_q;
               end
            end
         end
      end
   endgenerate

   // interrupt gate bit, unmasked after either reset
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         msk_q <= MSK_RST;
      end else if (ce) begin
         if (srst_q) begin
            msk_q <= MSK_RST;
         end else if (wr_end && addr_prev_q == {4'h0, LOC_IRQ}) begin
            msk_q <= bus_prev_q[MSK_BIT];
         end
      end
   end

   // read data and drive enable, both from flops
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         dd_q <= 8'h00;
         oe_q <= 1'b0;
      end else if (ce) begin
         oe_q <= rd_now;
         if (cur_addr < 8'(NUM_DATA_LOC)) begin
            dd_q <= loc_q[cur_addr[2:0]];
         end else if (cur_addr == {4'h0, LOC_IRQ}) begin
            dd_q <= 8'(core_irq) << MSK_BIT;
         end else if (cur_addr == {4'h0, LOC_SRST}) begin
            dd_q <= 8'(srst_q);
         end else begin
            dd_q <= 8'h00;
         end
      end
   end

   // interrupt pull-down, status stays visible when gated
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         int_q <= 1'b0;
      end else if (ce) begin
         int_q <= core_irq & msk_q & ~srst_q;
      end
   end

   // strobes toward the mailbox core
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wr_stb_q <= 1'b0;
         rd_stb_q <= 1'b0;
         wr_idx_q <= 4'h0;
         rd_idx_q <= 4'h0;
         wr_data_q <= 8'h00;
      end else if (ce) begin
         wr_stb_q <= wr_end & (addr_prev_q < 8'(NUM_DATA_LOC)) & ~srst_q;
         rd_stb_q <= rd_end & (addr_prev_q < 8'(NUM_DATA_LOC)) & ~srst_q;
         if (wr_end) begin
            wr_idx_q <= addr_prev_q[3:0];
            wr_data_q <= bus_prev_q;
         end
         if (rd_end) begin
            rd_idx_q <= addr_prev_q[3:0];
         end
      end
   end

   // outputs
   assign bus.dd_o = dd_q;
   assign bus.dd_oe = oe_q;
   assign bus.int_oe = int_q;
   assign core_rst = srst_q;
   assign wr_stb = wr_stb_q;
   assign wr_idx = wr_idx_q;
   assign wr_data = wr_data_q;
   assign rd_stb = rd_stb_q;
   assign rd_idx = rd_idx_q;
   assign bus_mode = mode_q;
endmodule // hbp_dev

// ---- hbp_host.sv ----
/*
 host end: apb slave registers that order single-byte accesses and
 drive the pins in the chosen bus style.
 assumes the device samples pins on the same pclk.
*/
module hbp_host
   import hbp_pkg::*;
(
   // clock, reset, enable
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic irq,
   // device pins
   hbp_if.host bus
);
   hbp_state_type state_q;
   hbp_mode_type style_q;
   logic [3:0] caddr_q;
   logic [7:0] cwdat_q, rdat_q, hd_q;
   logic crd_q;
   logic [2:0] cnt_q, ista_q, imsk_q, ev;
   logic wr_acc, start, bad, strb, cs_act, int_fall;

   // falling interrupt line is the device event
   hbp_edge u_int (
      .pclk(pclk),
      .presetn(presetn),
      .ce(ce),
      .din(bus.int_n),
      .prev(),
      .rise(),
      .fall(int_fall)
   );

   // apb decode, zero wait
   assign wr_acc = ce & psel & penable & pwrite;
   assign start = wr_acc & (paddr == OFS_CMD) & (state_q == H_IDLE);
   assign bad = pwdata[3:0] > LOC_SRST;
   assign pready = 1'b1;
   assign pslverr = psel & penable & ~((paddr == OFS_CTRL) | (paddr == OFS_CMD)
      | (paddr == OFS_RDAT) | (paddr == OFS_ISTA) | (paddr == OFS_IMSK));

   // register read mux
   always_comb begin
      if (paddr == OFS_CTRL) begin
         prdata = 32'(style_q);
      end else if (paddr == OFS_CMD) begin
         prdata = {15'h0, crd_q, cwdat_q, 4'h0, caddr_q};
      end else if (paddr == OFS_RDAT) begin
         prdata = {23'h0, state_q != H_IDLE, rdat_q};
      end else if (paddr == OFS_ISTA) begin
         prdata = {29'h0, ista_q};
      end else if (paddr == OFS_IMSK) begin
         prdata = {29'h0, imsk_q};
      end else begin
         prdata = 32'h0;
      end
   end

   // style, command and mask registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         style_q <= MODE_DS;
         caddr_q <= 4'h0;
         cwdat_q <= 8'h00;
         crd_q <= 1'b0;
         imsk_q <= IMSK_RST;
      end else if (wr_acc) begin
         if (paddr == OFS_CTRL) begin
            style_q <= hbp_mode_type'(pwdata[1:0]);
         end else if (start && !bad) begin
            caddr_q <= pwdata[3:0];
            cwdat_q <= pwdata[CMD_WDAT_LSB +: 8];
            crd_q <= pwdata[CMD_RD_BIT];
         end else if (paddr == OFS_IMSK) begin
            imsk_q <= pwdata[2:0];
         end
      end
   end

   // sticky events, write one clears, set wins
   assign ev[IST_DONE] = ce & (state_q == H_END);
   assign ev[IST_DINT] = ce & int_fall;
   assign ev[IST_BAD] = start & bad;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ista_q <= 3'h0;
      end else begin
         ista_q <= (ista_q & ~((wr_acc && paddr == OFS_ISTA) ? pwdata[2:0] : 3'h0)) | ev;
      end
   end
   assign irq = |(ista_q & imsk_q);

   // access sequencer and bus data
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_q <= H_IDLE;
         cnt_q <= 3'h0;
         hd_q <= 8'h00;
         rdat_q <= 8'h00;
      end else if (ce) begin
         case (state_q)
            H_IDLE: begin
               if (start && !bad) begin
                  hd_q <= (style_q == MODE_MUX) ? {4'h0, pwdata[3:0]}
                     : pwdata[CMD_WDAT_LSB +: 8];
                  state_q <= (style_q == MODE_MUX) ? H_ALE : H_SET;
               end
            end
            H_ALE: begin
               hd_q <= cwdat_q;
               state_q <= H_SET;
            end
            H_SET: begin
               cnt_q <= STRB_CNT;
               state_q <= H_STRB;
            end
            H_STRB: begin
               if (cnt_q == 3'h0) begin
                  if (crd_q) begin
                     rdat_q <= bus.ad;
                  end
                  state_q <= H_END;
               end else begin
                  cnt_q <= cnt_q - 3'h1;
               end
            end
            default: begin
               state_q <= H_IDLE;
            end
         endcase
      end
   end

   // pin levels per style
   assign cs_act = (state_q == H_SET) | (state_q == H_STRB) | (state_q == H_END);
   assign strb = state_q == H_STRB;
   assign bus.cs_n = ~cs_act;
   assign bus.ale = (style_q == MODE_DS)
      | ((style_q == MODE_MUX) & (state_q == H_ALE));
   assign bus.a = (style_q == MODE_MUX) ? MUX_APIN : {4'h0, caddr_q};
   assign bus.cycle_strobe_pin = ~(strb & (style_q == MODE_DS));
   assign bus.rw = crd_q;
   assign bus.rd_n = ~(strb & crd_q & (style_q != MODE_DS));
   assign bus.wr_n = ~(strb & ~crd_q & (style_q != MODE_DS));
   assign bus.hd_o = hd_q;
   assign bus.hd_oe = (state_q == H_ALE) | (~crd_q & (state_q == H_SET | strb));
endmodule // hbp_host

// ---- hbp_chk.sv ----
/*
 checker of the host bus port pins, fed the carrier signals plainly.
 assumes one clock domain, reset by the device end's reset.
*/
module hbp_chk
   import hbp_pkg::*;
(
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // host driven pins
   input wire logic cs_n,
   input wire logic rd_n,
   input wire logic wr_n,
   input wire logic cycle_strobe_pin,
   input wire logic rw,
   input wire logic ale,
   // device side
   input wire logic dd_oe,
   input wire logic int_oe,
   input wire logic core_irq,
   input wire hbp_mode_type bus_mode
);
   default clocking dc @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   logic [2:0] up_q;

   // cycles since reset release, saturating at four
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         up_q <= 3'h0;
      end else if (up_q != 3'h4) begin
         up_q <= up_q + 3'h1;
      end
   end

   // bus style selection
   strap_mode_a: assert property (up_q == 3'h3 && $stable(ale) |->
      bus_mode == (ale ? MODE_DS : MODE_SEP)) else $error("strap style wrong");
   edge_mux_a: assert property (up_q == 3'h4 && $changed(ale) |->
      ##[0:3] bus_mode == MODE_MUX) else $error("ale edge did not select mux");
   mux_sticks_a: assert property (bus_mode == MODE_MUX |=>
      bus_mode == MODE_MUX) else $error("left mux style without reset");
   // data line drive
   unsel_quiet_a: assert property (cs_n && $past(cs_n) |-> !dd_oe)
      else $error("data driven while unselected");
   drive_cause_a: assert property ($rose(dd_oe) |->
      $past(!cs_n && (!rd_n || (!cycle_strobe_pin && rw))))
      else $error("data driven outside a read");
   ds_write_a: assert property (!cs_n && !cycle_strobe_pin && !rw &&
      $past(!cycle_strobe_pin) && bus_mode == MODE_DS |-> !dd_oe)
      else $error("data driven in strobe write");
   ds_end_a: assert property (!cs_n && $rose(cycle_strobe_pin) &&
      bus_mode == MODE_DS |-> ##[1:2] !dd_oe) else $error("read drive kept");
   sep_write_a: assert property (!cs_n && !wr_n && $past(!wr_n) |-> !dd_oe)
      else $error("data driven in write");
   rd_end_a: assert property (!cs_n && $rose(rd_n) |-> ##[1:2] !dd_oe)
      else $error("read drive kept after strobe");
   // interrupt pull-down follows a pending request
   int_cause_a: assert property (!$past(core_irq) |-> !int_oe)
      else $error("interrupt pulled without request");

   // main scenarios reached
   cover property (!cs_n && !rd_n ##1 dd_oe);
   cover property (!cs_n && !cycle_strobe_pin && rw ##1 dd_oe);
   cover property (int_oe);
   cover property (bus_mode == MODE_MUX ##1 !cs_n);
endmodule // hbp_chk

// ---- dual_mode_host_bus_port_test.sv ----
/*
 self-checking bench: host end and device end joined by the carrier.
 assumes the apb slave answers with pready and a 50 MHz pclk.
*/
module dual_mode_host_bus_port_test
   import hbp_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic pclk = 1'b0;
   logic host_rstn, dev_rstn, ce, psel, penable, pwrite, pready, pslverr, irq;
   logic [7:0] paddr, wr_data, q, w_dat;
   logic [31:0] pwdata, prdata, r;
   logic [31:0] rnd = 32'h52D2;
   logic core_irq, core_rst, wr_stb, rd_stb, e;
   logic [3:0] wr_idx, rd_idx, w_idx, r_idx;
   hbp_mode_type bus_mode;
   int error_cnt = 0;
   int num_checks = 0;
   int cyc = 0;
   int wr_cnt = 0;
   int rd_cnt = 0;
   hbp_if bus_if();

   // both ends and the pin checker
   hbp_host i_hbp_host (.pclk(pclk), .presetn(host_rstn), .ce(ce), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .irq(irq), .bus(bus_if.host));
   hbp_dev i_hbp_dev (.pclk(pclk), .presetn(dev_rstn), .ce(ce), .bus(bus_if.dev),
      .core_irq(core_irq), .core_rst(core_rst), .wr_stb(wr_stb), .wr_idx(wr_idx),
      .wr_data(wr_data), .rd_stb(rd_stb), .rd_idx(rd_idx), .bus_mode(bus_mode));
   hbp_chk i_hbp_chk (.pclk(pclk), .presetn(dev_rstn), .cs_n(bus_if.cs_n),
      .rd_n(bus_if.rd_n), .wr_n(bus_if.wr_n), .cycle_strobe_pin(bus_if.cycle_strobe_pin),
      .rw(bus_if.rw), .ale(bus_if.ale), .dd_oe(bus_if.dd_oe), .int_oe(bus_if.int_oe),
      .core_irq(core_irq), .bus_mode(bus_mode));

   // clock
   always #10 pclk = ~pclk;

   // core strobe monitor and hang guard
   always @(posedge pclk) begin
      cyc++;
      if (wr_stb === 1'b1) begin
         wr_cnt++;
         w_idx = wr_idx;
         w_dat = wr_data;
      end
      if (rd_stb === 1'b1) begin
         rd_cnt++;
         r_idx = rd_idx;
      end
      if (cyc == 20000) begin
         error_cnt++;
         $display("unexpected at %0t: run did not finish", $time);
         test_done();
      end
   end

   function automatic logic [31:0] lfsr(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction
   function automatic hbp_mode_type exp_mode(input logic strap);
      return strap ? MODE_DS : MODE_SEP;
   endfunction

   task automatic chk(input bit ok, input string m);
      num_checks++;
      if (!ok) begin
         error_cnt++;
         $display("unexpected at %0t: %s", $time, m);
      end
   endtask
   task automatic tend(input string m);
      $display("test %s done", m);
   endtask

   // one apb transfer, held until pready is seen
   task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] wd,
         output logic [31:0] rd, output logic er);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= ad;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      // no timeout here: pready ends this wait, else the hang guard
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   // one device access through the command register, waits out busy
   task automatic acc(input logic rdc, input logic [3:0] loc, input logic [7:0] wd,
         output logic [7:0] qo);
      logic [31:0] v;
      logic er;
      apb(1'b1, OFS_CMD, {15'h0000, rdc, wd, 4'h0, loc}, v, er);
      do begin
         apb(1'b0, OFS_RDAT, 32'h0, v, er);
      end while (v[RDAT_BUSY_BIT] !== 1'b0);
      qo = v[7:0];
   endtask
   task automatic wr_chk(input logic [3:0] loc, input logic [7:0] wd);
      int c0;
      logic [7:0] t;
      c0 = wr_cnt;
      acc(1'b0, loc, wd, t);
      repeat (2) @(posedge pclk);
      chk(wr_cnt == c0 + 1 && w_idx === loc && w_dat === wd, "write not delivered");
   endtask
   task automatic rd_chk(input logic [3:0] loc, input logic [7:0] ex);
      int c0;
      logic [7:0] t;
      c0 = rd_cnt;
      acc(1'b1, loc, 8'h00, t);
      repeat (2) @(posedge pclk);
      chk(t === ex && rd_cnt == c0 + 1 && r_idx === loc, "read data wrong");
   endtask

   task automatic test_done();
      $display("checks %0d mismatches %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   // main sequence
   initial begin
      host_rstn = 1'b0;
      dev_rstn = 1'b0;
      ce = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      core_irq = 1'b0;
      repeat (12) @(posedge pclk);
      host_rstn <= 1'b1;
      dev_rstn <= 1'b1;
      repeat (6) @(posedge pclk);
      chk(bus_mode === exp_mode(1'b1), "strap style");
      apb(1'b0, OFS_CTRL, 32'h0, r, e);
      chk(r[1:0] === 2'b00 && e === 1'b0, "style reset value");
      apb(1'b0, OFS_IMSK, 32'h0, r, e);
      chk(r[2:0] === IMSK_RST, "mask reset value");
      apb(1'b0, 8'h20, 32'h0, r, e);
      chk(e === 1'b1 && r === 32'h0, "unmapped offset");
      tend("reset");
      for (int i = 0; i < NUM_DATA_LOC; i++) begin
         rnd = lfsr(rnd);
         wr_chk(4'(i), rnd[7:0]);
         rd_chk(4'(i), rnd[7:0]);
      end
      apb(1'b0, OFS_ISTA, 32'h0, r, e);
      chk(r[IST_DONE] === 1'b1, "done status");
      tend("data strobe");
      apb(1'b1, OFS_IMSK, 32'h4, r, e);
      for (int i = 9; i < 16; i += 6) begin
         rnd[3:0] = 4'(wr_cnt);
         acc(1'b0, 4'(i), 8'hA5, q);
         apb(1'b0, OFS_ISTA, 32'h0, r, e);
         chk(r[IST_BAD] === 1'b1 && irq === 1'b1 && 4'(wr_cnt) === rnd[3:0], "reserved");
         apb(1'b1, OFS_ISTA, 32'h4, r, e);
         @(posedge pclk);
         chk(irq === 1'b0, "status clear");
      end
      tend("reserved");
      // enable low must freeze the interrupt pull-down
      @(posedge pclk);
      ce <= 1'b0;
      core_irq <= 1'b1;
      repeat (3) @(posedge pclk);
      chk(bus_if.int_n === 1'b1, "enable low froze state");
      ce <= 1'b1;
      repeat (3) @(posedge pclk);
      chk(bus_if.int_n === 1'b0, "interrupt line");
      acc(1'b1, LOC_IRQ, 8'h00, q);
      chk(q[MSK_BIT] === 1'b1, "pending status");
      apb(1'b0, OFS_ISTA, 32'h0, r, e);
      chk(r[IST_DINT] === 1'b1, "interrupt seen");
      acc(1'b0, LOC_IRQ, 8'h00, q);
      repeat (3) @(posedge pclk);
      chk(bus_if.int_n === 1'b1, "masked line");
      acc(1'b1, LOC_IRQ, 8'h00, q);
      chk(q[MSK_BIT] === 1'b1, "status while masked");
      acc(1'b0, LOC_IRQ, 8'h04, q);
      repeat (3) @(posedge pclk);
      chk(bus_if.int_n === 1'b0, "unmasked line");
      tend("interrupt");
      acc(1'b0, LOC_SRST, 8'h01, q);
      chk(core_rst === 1'b1 && bus_if.int_n === 1'b1, "soft reset on");
      acc(1'b1, LOC_SRST, 8'h00, q);
      chk(q[SRST_BIT] === 1'b1, "soft reset bit");
      acc(1'b0, LOC_SRST, 8'h00, q);
      chk(core_rst === 1'b0, "soft reset off");
      rd_chk(4'h0, 8'h00);
      core_irq <= 1'b0;
      tend("soft reset");
      apb(1'b1, OFS_CTRL, 32'h3, r, e);
      rnd = lfsr(rnd);
      wr_chk(4'h3, rnd[7:0]);
      rd_chk(4'h3, rnd[7:0]);
      chk(bus_mode === MODE_MUX, "mux style");
      chk(bus_if.a === MUX_APIN, "address pins in mux");
      apb(1'b1, OFS_CTRL, 32'h0, r, e);
      repeat (5) @(posedge pclk);
      chk(bus_mode === MODE_MUX, "mux kept");
      tend("multiplexed");
      apb(1'b1, OFS_CTRL, 32'h1, r, e);
      repeat (3) @(posedge pclk);
      dev_rstn <= 1'b0;
      repeat (3) @(posedge pclk);
      dev_rstn <= 1'b1;
      repeat (6) @(posedge pclk);
      chk(bus_mode === exp_mode(1'b0), "strap separate");
      for (int i = 0; i < 3; i++) begin
         rnd = lfsr(rnd);
         wr_chk(rnd[11:8] % 4'h7, rnd[7:0]);
         rd_chk(rnd[11:8] % 4'h7, rnd[7:0]);
      end
      chk(bus_if.a[7:4] === 4'h0, "upper address lines");
      tend("separate strobes");
      test_done();
   end
endmodule // dual_mode_host_bus_port_test
